// >>> sqe_defines.svh
// sqe_defines.svh: offsets, field positions, reset values and timing counts of the shared queue-enable register bank
// assumes: included by the package and the design files, byte addresses are four times the word index
//
// Behaviour
// - upper master word: bit0 queue16, bit15 queue31
// - lower master word: bit0 queue0, bit15 queue15
// - master bit one enables queue sharing
// - sharing covers at most thirty-two queues
// - upper slave word: bit0 slave queue16
`ifndef SQE_DEFINES_SVH
`define SQE_DEFINES_SVH

// --------------------------------------------------------------
// word indices as printed, byte address is index times four
// --------------------------------------------------------------
`define SQE_IDX_MASTER_UPPER  10'h15C
`define SQE_IDX_MASTER_LOWER  10'h15E
`define SQE_IDX_SLAVE_UPPER   10'h16C
`define SQE_IDX_CONTROL       10'h170
`define SQE_IDX_OFFER_STATUS  10'h172
`define SQE_ADDR_MASTER_UPPER {`SQE_IDX_MASTER_UPPER, 2'b00}
`define SQE_ADDR_MASTER_LOWER {`SQE_IDX_MASTER_LOWER, 2'b00}
`define SQE_ADDR_SLAVE_UPPER  {`SQE_IDX_SLAVE_UPPER, 2'b00}
`define SQE_ADDR_CONTROL      {`SQE_IDX_CONTROL, 2'b00}
`define SQE_ADDR_OFFER_STATUS {`SQE_IDX_OFFER_STATUS, 2'b00}

// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define SQE_HALF_MSB          15
`define SQE_CTRL_SHARED_BIT   0
`define SQE_CTRL_MASTER_BIT   1
`define SQE_HALF_RESET        16'h0000
`define SQE_CTRL_RESET        2'h0
`define SQE_WORD_ZERO         32'h0000_0000

// --------------------------------------------------------------
// timing: wait states inserted by the slave per access
// --------------------------------------------------------------
`define SQE_APB_WAIT_STATES   1

`endif

// >>> sqe_pkg.sv
// sqe_pkg.sv: types shared by the queue-enable register bank and its gate
// assumes: sqe_defines.svh is reachable on the include path
`include "sqe_defines.svh"

package sqe_pkg;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef logic [`SQE_HALF_MSB:0] sqe_half_t;   // one 16-queue enable word
	typedef logic [31:0]            sqe_mask_t;   // one bit per shared queue

	// apb slave phase, one-hot
	typedef enum logic [1:0]
	{
		SQE_ST_IDLE = 2'b01,
		SQE_ST_RESP = 2'b10
	} sqe_apb_e;

endpackage : sqe_pkg

// >>> sqe_queue_gate.sv
// sqe_queue_gate.sv: per-queue decision of which queues may offer a cell on the shared bus
// assumes: all inputs are on pclk, the caller registers the outputs
`include "sqe_defines.svh"

module sqe_queue_gate
	import sqe_pkg::*;
(
	// enables from the register bank
	input  wire logic      shared_mode,
	input  wire logic      is_master,
	input  wire sqe_mask_t master_enable,
	input  wire sqe_mask_t slave_enable,
	// queue fill state
	input  wire sqe_mask_t cell_pending,
	input  wire sqe_mask_t peer_pending,
	// decisions
	output logic           [31:0] local_grant,
	output logic           [31:0] peer_grant
);

	// --------------------------------------------------------------
	// one lane per queue; only 32 lanes exist at all
	// --------------------------------------------------------------
	// thirty-two lanes only
	for (genvar q = 0; q < 32; q++)
	begin : g_queue
		// outside shared mode the enables are kept but do not gate
		// bit one enables
		assign local_grant[q] = cell_pending[q] & (master_enable[q] | ~shared_mode);
		// slave words only in shared master
		assign peer_grant[q]  = peer_pending[q] & slave_enable[q] & shared_mode & is_master;
	end

endmodule : sqe_queue_gate

// >>> sqe_regs.sv
// sqe_regs.sv: apb register bank for shared bus queue enables, plus the registered offer masks
// assumes: apb master on pclk, cell_pending from local queue logic on pclk,
// peer_pending_async from the peer device pins (asynchronous)
`include "sqe_defines.svh"

module sqe_regs
	import sqe_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// queue state
	input  wire logic [31:0] cell_pending,
	input  wire logic [31:0] peer_pending_async,
	input  wire logic [15:0] slave_enable_lower,
	// offers on the shared bus
	output logic      [31:0] local_offer,
	output logic      [31:0] peer_offer
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	sqe_apb_e  state;                               // apb phase
	sqe_apb_e  next_state;
	sqe_half_t master_queue_enable_upper_half;      // queues 16..31
	sqe_half_t next_master_queue_enable_upper_half;
	sqe_half_t master_queue_enable_lower_half;      // queues 0..15
	sqe_half_t next_master_queue_enable_lower_half;
	sqe_half_t slave_queue_enable_upper_half;       // slave queues 16..31
	sqe_half_t next_slave_queue_enable_upper_half;
	logic      shared_mode;                         // shared bus active
	logic      next_shared_mode;
	logic      is_master;                           // this device arbitrates
	logic      next_is_master;
	logic      [31:0] next_prdata;
	logic      next_pready;
	logic      next_pslverr;
	logic      [31:0] peer_meta;                    // first sync stage only
	logic      [31:0] peer_sync;                    // safe to read
	logic      [31:0] local_grant;
	logic      [31:0] peer_grant;
	logic      addr_hit;                            // decoded address
	logic      wr_fire;                             // write takes effect now

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	always_comb
	begin
		unique case (paddr)
			`SQE_ADDR_MASTER_UPPER, `SQE_ADDR_MASTER_LOWER, `SQE_ADDR_SLAVE_UPPER,
			`SQE_ADDR_CONTROL, `SQE_ADDR_OFFER_STATUS:
				addr_hit = 1'b1;
			default:
				addr_hit = 1'b0;              // unmapped, answered with pslverr
		endcase
	end

	// effect only at the edge that samples pready high
	assign wr_fire = psel & penable & pready & pwrite & addr_hit;

	// --------------------------------------------------------------
	// apb handshake: one wait state, answer from flops
	// --------------------------------------------------------------
	always_comb
	begin
		next_state   = state;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = `SQE_WORD_ZERO;
		unique case (state)
			SQE_ST_IDLE:
			begin
				// access phase seen: prepare the answer for the next edge
				if (psel && penable)
				begin
					next_state   = SQE_ST_RESP;
					next_pready  = 1'b1;
					next_pslverr = ~addr_hit;
					if (!pwrite)
					begin
						unique case (paddr)
							`SQE_ADDR_MASTER_UPPER: next_prdata = {16'h0000, master_queue_enable_upper_half};
							`SQE_ADDR_MASTER_LOWER: next_prdata = {16'h0000, master_queue_enable_lower_half};
							`SQE_ADDR_SLAVE_UPPER:  next_prdata = {16'h0000, slave_queue_enable_upper_half};
							`SQE_ADDR_CONTROL:      next_prdata = {30'h0000_0000, is_master, shared_mode};
							`SQE_ADDR_OFFER_STATUS: next_prdata = local_offer;
							default:                next_prdata = `SQE_WORD_ZERO;
						endcase
					end
				end
			end
			SQE_ST_RESP:
			begin
				// transfer completes here, master releases or starts anew
				next_state = SQE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state   <= SQE_ST_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `SQE_WORD_ZERO;
		end
		else
		begin
			state   <= next_state;
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// --------------------------------------------------------------
	// register writes; upper data bits ignored
	// --------------------------------------------------------------
	always_comb
	begin
		next_master_queue_enable_upper_half = master_queue_enable_upper_half;
		next_master_queue_enable_lower_half = master_queue_enable_lower_half;
		next_slave_queue_enable_upper_half  = slave_queue_enable_upper_half;
		next_shared_mode                    = shared_mode;
		next_is_master                      = is_master;
		if (wr_fire)
		begin
			unique case (paddr)
				`SQE_ADDR_MASTER_UPPER: next_master_queue_enable_upper_half = pwdata[15:0];
				`SQE_ADDR_MASTER_LOWER: next_master_queue_enable_lower_half = pwdata[15:0];
				`SQE_ADDR_SLAVE_UPPER:  next_slave_queue_enable_upper_half  = pwdata[15:0];
				`SQE_ADDR_CONTROL:
				begin
					next_shared_mode = pwdata[`SQE_CTRL_SHARED_BIT];
					next_is_master   = pwdata[`SQE_CTRL_MASTER_BIT];
				end
				default:
				begin
					// status is read only
					next_shared_mode = shared_mode;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			master_queue_enable_upper_half <= `SQE_HALF_RESET;
			master_queue_enable_lower_half <= `SQE_HALF_RESET;
			slave_queue_enable_upper_half  <= `SQE_HALF_RESET;
			shared_mode                    <= 1'b0;
			is_master                      <= 1'b0;
		end
		else
		begin
			master_queue_enable_upper_half <= next_master_queue_enable_upper_half;
			master_queue_enable_lower_half <= next_master_queue_enable_lower_half;
			slave_queue_enable_upper_half  <= next_slave_queue_enable_upper_half;
			shared_mode                    <= next_shared_mode;
			is_master                      <= next_is_master;
		end
	end

	// --------------------------------------------------------------
	// peer pending: two-flop synchroniser per bit
	// --------------------------------------------------------------
	// bits cross independently; a skew of one cycle between lanes is harmless
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			peer_meta <= `SQE_WORD_ZERO;
			peer_sync <= `SQE_WORD_ZERO;
		end
		else
		begin
			peer_meta <= peer_pending_async;
			peer_sync <= peer_meta;
		end
	end

	// --------------------------------------------------------------
	// offer decision and its output flops
	// --------------------------------------------------------------
	// offers gated by enables in shared mode
	sqe_queue_gate u_gate
	(
		.shared_mode   (shared_mode),
		.is_master     (is_master),
		.master_enable ({master_queue_enable_upper_half, master_queue_enable_lower_half}),
		.slave_enable  ({slave_queue_enable_upper_half, slave_enable_lower}),
		.cell_pending  (cell_pending),
		.peer_pending  (peer_sync),
		.local_grant   (local_grant),
		.peer_grant    (peer_grant)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			local_offer <= `SQE_WORD_ZERO;
			peer_offer  <= `SQE_WORD_ZERO;
		end
		else
		begin
			local_offer <= local_grant;
			peer_offer  <= peer_grant;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_access;
		psel && penable && !pready ##1 pready;
	endsequence

	a_upper_map: assert property ($past(shared_mode) |->
		(local_offer[31:16] & ~$past(master_queue_enable_upper_half)) == 16'h0000)
		else $error("upper master word let a disabled queue offer");

	a_lower_map: assert property ($past(shared_mode) |->
		(local_offer[15:0] & ~$past(master_queue_enable_lower_half)) == 16'h0000)
		else $error("lower master word let a disabled queue offer");

	a_enable_offer: assert property ($past(shared_mode) |->
		local_offer == ($past(cell_pending)
		& {$past(master_queue_enable_upper_half), $past(master_queue_enable_lower_half)}))
		else $error("local offer does not follow pending and enable");

	// only the low sixteen data bits land
	a_half_width: assert property (wr_fire && paddr == `SQE_ADDR_MASTER_UPPER |=>
		master_queue_enable_upper_half == $past(pwdata[15:0]))
		else $error("upper master word write lost or widened");

	a_slave_map: assert property ($past(shared_mode && is_master) |->
		(peer_offer[31:16] & ~$past(slave_queue_enable_upper_half)) == 16'h0000)
		else $error("slave word let a disabled slave queue offer");

	// no peer offers unless shared master
	a_peer_gate: assert property (!$past(shared_mode && is_master) |->
		peer_offer == `SQE_WORD_ZERO)
		else $error("peer queue offered outside shared master mode");

	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered after one wait state");

	a_ready_pulse: assert property (s_access |=> !pready)
		else $error("pready held longer than one cycle");

	a_unmapped_err: assert property (pready |-> pslverr == !$past(addr_hit))
		else $error("pslverr does not match address decode");

endmodule : sqe_regs

// >>> sqe_peer_model.sv
// sqe_peer_model.sv: behavioural peer device on the far side of the shared bus
// assumes: the bench sets what the peer holds, pending pins reach the bank unsynchronised
module sqe_peer_model
	import sqe_pkg::*;
(
	// settings from the bench
	input  wire logic [31:0] fill,
	input  wire logic [15:0] lower_en,
	// pins toward the bank
	output logic      [31:0] peer_pending_async,
	output logic      [15:0] slave_enable_lower
);
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// pin behaviour
	// --------------------------------------------------------------
	// thirty-two queues only
	// pins move off the clock grid, so the synchroniser is really exercised
	assign #13 peer_pending_async = fill;
	// neighbouring register, same clock domain, plain copy
	assign slave_enable_lower = lower_en;
endmodule : sqe_peer_model

// >>> sqe_regs_tb.sv
// sqe_regs_tb.sv: self-checking bench for the queue-enable register bank
// assumes: sqe_defines.svh on the include path, one wait state per apb access
`include "sqe_defines.svh"

module sqe_regs_tb
	import sqe_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic        pclk, presetn;              // clock and reset
	logic        psel, penable, pwrite;      // apb controls
	logic [11:0] paddr;                      // byte address
	logic [31:0] pwdata, prdata;             // apb data
	logic        pready, pslverr;            // apb answer
	logic [31:0] cell_pending, fill;         // local and peer queue fill
	logic [15:0] lower_en, slave_enable_lower;
	logic [31:0] peer_pending_async, local_offer, peer_offer;
	logic [31:0] rd;                         // last read data
	logic        er;                         // last error flag
	int          num_errors, n_compared;     // verdict counters
	logic [11:0] regs [3] = '{`SQE_ADDR_MASTER_UPPER, `SQE_ADDR_MASTER_LOWER, `SQE_ADDR_SLAVE_UPPER};
	logic [31:0] pat  [3] = '{32'hFFFF_A5C3, 32'hDEAD_3C5A, 32'h5555_0F0F}; // upper bits must drop

	sqe_regs uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cell_pending(cell_pending), .peer_pending_async(peer_pending_async),
		.slave_enable_lower(slave_enable_lower), .local_offer(local_offer), .peer_offer(peer_offer));
	sqe_peer_model peer (.fill(fill), .lower_en(lower_en), .peer_pending_async(peer_pending_async),
		.slave_enable_lower(slave_enable_lower));

	// 25 MHz clock
	always #20 pclk = ~pclk;

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	// verdict, the only place the run ends
	task automatic close_out();
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// value compare, case equality so unknowns fail
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// hold until ready is seen at an edge; only the watchdog ends a hang
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		// one wait state: ready is seen at the second access-phase edge
		chk(n, 32'h2);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup is not in the same step
		@(posedge pclk);
	endtask : apb

	// read and check data and error
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, experr});
	endtask : rchk

	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial
	begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		cell_pending = 0; fill = 0; lower_en = 0; num_errors = 0; n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values, read-write and 16-bit width of each word, written outside shared mode
		foreach (regs[i])
		begin
			rchk(regs[i], 32'h0, 1'h0);
			apb(regs[i], 1'b1, pat[i]);
			rchk(regs[i], pat[i] & 32'h0000_FFFF, 1'h0);
		end
		rchk(`SQE_ADDR_CONTROL, 32'h0, 1'h0);
		// unmapped place answers zero with error, a write there errors too
		rchk(12'h004, 32'h0, 1'h1);
		apb(12'h004, 1'b1, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		// outside shared mode the words are stored but do not gate
		cell_pending <= 32'hFFFF_FFFF;
		repeat (2) @(posedge pclk);
		chk(local_offer, 32'hFFFF_FFFF);
		// shared mode as slave: the master words gate here as well
		apb(`SQE_ADDR_CONTROL, 1'b1, 32'h1);
		repeat (2) @(posedge pclk);
		chk(local_offer, 32'hA5C3_3C5A);
		rchk(`SQE_ADDR_OFFER_STATUS, 32'hA5C3_3C5A, 1'h0);
		// status is read only: a write is ignored without error
		apb(`SQE_ADDR_OFFER_STATUS, 1'b1, 32'h0);
		chk({31'h0, er}, 32'h0);
		rchk(`SQE_ADDR_OFFER_STATUS, 32'hA5C3_3C5A, 1'h0);
		// boundary queues 0, 15, 16
		cell_pending <= 32'h0001_8001;
		repeat (2) @(posedge pclk);
		chk(local_offer, 32'h0001_0000);
		// slave enables unused when not master
		fill     <= 32'hFFFF_FFFF;
		lower_en <= 16'h1234;
		repeat (6) @(posedge pclk);
		chk(peer_offer, 32'h0);
		apb(`SQE_ADDR_CONTROL, 1'b1, 32'h3);
		repeat (2) @(posedge pclk);
		chk(peer_offer, 32'h0F0F_1234);
		fill <= 32'h0001_8000;
		repeat (6) @(posedge pclk);
		chk(peer_offer, 32'h0001_0000);
		// master without shared mode: slave words unused, master words do not gate
		apb(`SQE_ADDR_CONTROL, 1'b1, 32'h2);
		repeat (2) @(posedge pclk);
		chk(peer_offer, 32'h0);
		chk(local_offer, 32'h0001_8001);
		rchk(`SQE_ADDR_CONTROL, 32'h2, 1'h0);
		// reset in mid-run clears every word and offer
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(local_offer, 32'h0);
		chk(peer_offer, 32'h0);
		// shared mode, already off before the reset, stays off: pending queues pass ungated again
		@(posedge pclk);
		chk(local_offer, 32'h0001_8001);
		rchk(`SQE_ADDR_MASTER_UPPER, 32'h0, 1'h0);
		rchk(`SQE_ADDR_CONTROL, 32'h0, 1'h0);
		close_out();
	end

	// watchdog, far beyond the 120 or so cycles the tests need
	initial
	begin
		repeat (3000) @(posedge pclk);
		num_errors++;
		close_out();
	end
endmodule : sqe_regs_tb
